// ===== rtl/drs_pkg.sv
package drs_pkg;

	// Register byte offsets inside the drawing register window.
	localparam logic [13:0] OFS_MEM_ACCESS = 14'h1C04;
	localparam logic [13:0] OFS_FG_COLOUR = 14'h1C24;
	localparam logic [13:0] OFS_LENGTH = 14'h1C5C;
	localparam logic [13:0] OFS_BND_PAIR = 14'h1C84;
	localparam logic [13:0] OFS_LEFT = 14'h1CA8;
	localparam logic [13:0] OFS_RIGHT = 14'h1CAC;
	localparam logic [13:0] OFS_STATUS = 14'h1E10;
	localparam logic [13:0] OFS_ICLR = 14'h1E18;
	localparam logic [13:0] OFS_IEN = 14'h1E1C;

	// Host write queue geometry; an entry is offset plus data.
	localparam int FIFO_AW = 6;
	localparam logic [6:0] FIFO_DEPTH = 7'h40;
	localparam int QW = 46;

	// Status word layout and reset value.
	localparam int ST_FREE_MSB = 6;
	localparam int ST_FULL_BIT = 8;
	localparam int ST_EMPTY_BIT = 9;
	localparam logic [31:0] STATUS_RESET = 32'h0000_0240;

	// Interrupt bit positions, writable mask and reset value.
	localparam int IRQ_PICK_BIT = 2;
	localparam int IRQ_VLINE_BIT = 5;
	localparam int IRQ_EXT_BIT = 6;
	localparam logic [31:0] IEN_MASK = 32'h0000_0064;
	localparam logic [31:0] IEN_RESET = 32'h0000_0000;

	// Memory access configuration fields.
	localparam int MA_PW_LSB = 0;
	localparam int MA_ZW_BIT = 3;
	localparam int MA_MEMRST_BIT = 15;
	localparam int MA_TLUT_BIT = 29;
	localparam int MA_NODITH_BIT = 30;
	localparam int MA_D555_BIT = 31;

	// Length register fields.
	localparam int LEN_BETA_LSB = 28;
	localparam logic [4:0] BETA_ZERO_VALUE = 5'h10;

	// Consecutive retries answered before a write is given up.
	localparam logic [4:0] RETRY_LIMIT = 5'h10;

	typedef enum logic [1:0] {
		DEPTH_8BPP = 2'b00,
		DEPTH_16BPP = 2'b01,
		DEPTH_32BPP = 2'b10,
		DEPTH_24BPP = 2'b11
	} drs_depth_t;

endpackage

// ===== rtl/drs_write_queue.sv
`timescale 1ns/1ps
module drs_write_queue
	import drs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic flush,
	input wire logic push,
	input wire logic [QW-1:0] push_data,
	input wire logic pop,
	output logic [QW-1:0] pop_data,
	output logic [6:0] free_cnt,
	output logic full,
	output logic empty
);
	logic [QW-1:0] mem [0:63];
	logic [FIFO_AW-1:0] wr_ptr_q;
	logic [FIFO_AW-1:0] rd_ptr_q;
	logic [6:0] used_q;
	logic do_push;
	logic do_pop;

	assign full = (used_q == FIFO_DEPTH);
	assign empty = (used_q == 7'h00);
	assign free_cnt = FIFO_DEPTH - used_q;
	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	assign pop_data = mem[rd_ptr_q];

	always_ff @(posedge sys_clk) begin
		if (clk_en && do_push) begin
			mem[wr_ptr_q] <= push_data;
		end
	end

	// Hard or soft reset flushes the queue back to all entries free.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			used_q <= 7'h00;
		end else if (clk_en) begin
			if (flush) begin
				wr_ptr_q <= '0;
				rd_ptr_q <= '0;
				used_q <= 7'h00;
			end else begin
				wr_ptr_q <= wr_ptr_q + FIFO_AW'(do_push);
				rd_ptr_q <= rd_ptr_q + FIFO_AW'(do_pop);
				used_q <= used_q + 7'(do_push) - 7'(do_pop);
			end
		end
	end
endmodule

// ===== rtl/drs_pixel_path.sv
`timescale 1ns/1ps
module drs_pixel_path
	import drs_pkg::*;
(
	input wire logic [31:0] fg_colour,
	input wire logic [31:0] bg_colour,
	input wire logic [31:0] src_pix,
	input wire logic [31:0] shade_pix,
	input wire logic [1:0] depth,
	input wire logic block_mode,
	input wire logic expand,
	input wire logic expand_bit,
	input wire logic transc,
	input wire logic gouraud,
	input wire logic fmt_555,
	output logic [31:0] pix_out,
	output logic pix_we
);
	logic [31:0] fg_eff;
	logic [31:0] expanded;
	logic [31:0] shaded;
	logic key_hit;
	logic is_24;

	assign is_24 = (depth == DEPTH_24BPP);
	// The top byte is dropped at 24 bpp except in block mode.
	assign fg_eff = (is_24 && !block_mode) ?
		{8'h00, fg_colour[23:0]} : fg_colour;
	assign expanded = expand_bit ? fg_eff : bg_colour;
	// Background colour doubles as the key mask, foreground as the key.
	assign key_hit = ((src_pix & bg_colour) == fg_colour);
	assign shaded = (depth == DEPTH_32BPP) ?
		{fg_colour[31:24], shade_pix[23:0]} :
		(depth == DEPTH_16BPP && fmt_555) ?
		{shade_pix[31:16], fg_colour[31], shade_pix[14:0]} : shade_pix;
	assign pix_out = gouraud ? shaded : (expand ? expanded : src_pix);
	assign pix_we = gouraud ? 1'b1 :
		(expand ? (expand_bit || !transc) : !(transc && key_hit));
endmodule

// ===== rtl/drs_reg_slice.sv
`timescale 1ns/1ps
module drs_reg_slice
	import drs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic soft_rst,
	input wire logic [13:0] host_addr,
	input wire logic host_wr,
	input wire logic [31:0] host_wdata,
	input wire logic host_rd_start,
	output logic [31:0] host_rdata,
	output logic host_retry,
	output logic host_retry_abort,
	input wire logic eng_ready,
	input wire logic op_host_load,
	input wire logic op_blit,
	input wire logic op_hq_hv_load,
	input wire logic op_trap,
	input wire logic op_shaded,
	input wire logic op_unfmt_load,
	input wire logic atype_block,
	input wire logic edge_left_step,
	input wire logic [15:0] edge_left_next,
	input wire logic edge_right_step,
	input wire logic [15:0] edge_right_next,
	input wire logic pick_event,
	input wire logic vline_event,
	input wire logic ext_irq,
	output logic host_irq_line_n,
	input wire logic px_valid,
	input wire logic px_expand,
	input wire logic px_expand_bit,
	input wire logic px_transc,
	input wire logic px_gouraud,
	input wire logic [31:0] px_src,
	input wire logic [31:0] px_shade,
	input wire logic [31:0] bg_colour,
	output logic [31:0] px_out,
	output logic px_we,
	output logic px_out_valid,
	output logic [1:0] depth_sel,
	output logic depth_size_32,
	output logic mem_reset_cycle,
	output logic tlut_target,
	output logic dither_en,
	output logic dither_format_select,
	output logic [15:0] draw_length,
	output logic [4:0] vscale_beta,
	output logic [15:0] fill_left,
	output logic [15:0] fill_right,
	output logic [31:0] fg_colour,
	output logic queue_idle
);
	// Host side decode.
	wire hit_status = (host_addr == OFS_STATUS);
	wire hit_iclr = (host_addr == OFS_ICLR);
	wire hit_ien = (host_addr == OFS_IEN);
	wire hit_queued = (host_addr == OFS_MEM_ACCESS) ||
		(host_addr == OFS_FG_COLOUR) || (host_addr == OFS_LENGTH) ||
		(host_addr == OFS_BND_PAIR) || (host_addr == OFS_LEFT) ||
		(host_addr == OFS_RIGHT);

	// Write queue.
	logic [QW-1:0] q_out;
	logic [6:0] q_free;
	logic q_full;
	logic q_empty;
	wire q_push = host_wr && hit_queued;
	wire q_pop = eng_ready && !q_empty;

	drs_write_queue u_queue (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.flush(soft_rst),
		.push(q_push),
		.push_data({host_addr, host_wdata}),
		.pop(q_pop),
		.pop_data(q_out),
		.free_cnt(q_free),
		.full(q_full),
		.empty(q_empty)
	);

	// Drained entry decode on the engine side.
	wire [13:0] d_addr = q_out[QW-1:32];
	wire [31:0] d_data = q_out[31:0];
	wire ld_macc = q_pop && (d_addr == OFS_MEM_ACCESS);
	wire ld_foreground_colour_key = q_pop && (d_addr == OFS_FG_COLOUR);
	wire ld_len = q_pop && (d_addr == OFS_LENGTH);
	wire ld_pair = q_pop && (d_addr == OFS_BND_PAIR);
	wire ld_left = q_pop && (d_addr == OFS_LEFT);
	wire ld_right = q_pop && (d_addr == OFS_RIGHT);

	// Stored configuration.
	logic [31:0] macc_q;
	logic [31:0] macc_d;
	logic [31:0] foreground_colour_key_q;
	logic [31:0] foreground_colour_key_d;
	logic [31:0] len_q;
	logic [31:0] len_d;
	logic [15:0] left_q;
	logic [15:0] left_d;
	logic [15:0] right_q;
	logic [15:0] right_d;

	assign macc_d = ld_macc ? d_data : macc_q;
	assign foreground_colour_key_d = ld_foreground_colour_key ? d_data : foreground_colour_key_q;
	assign len_d = ld_len ? d_data : len_q;

	// The pair alias has no storage of its own; it writes both edges.
	// Edges track the scan only during trapezoids and hold otherwise.
	assign left_d = ld_pair ? d_data[15:0] :
		ld_left ? d_data[15:0] :
		(op_trap && edge_left_step) ? edge_left_next : left_q;
	assign right_d = ld_pair ? d_data[31:16] :
		ld_right ? d_data[15:0] :
		(op_trap && edge_right_step) ? edge_right_next : right_q;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			macc_q <= 32'h0000_0000;
			foreground_colour_key_q <= 32'h0000_0000;
			len_q <= 32'h0000_0000;
		end else if (clk_en) begin
			macc_q <= macc_d;
			foreground_colour_key_q <= foreground_colour_key_d;
			len_q <= len_d;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			left_q <= 16'h0000;
			right_q <= 16'h0000;
		end else if (clk_en) begin
			left_q <= left_d;
			right_q <= right_d;
		end
	end

	// Queue status word; free count spans bits 6:0 so bit 6 is empty.
	wire [31:0] status_live = {22'h0, q_empty, q_full, 1'b0,
		q_free};

	// Retry handling for writes that find no free entry.
	// A write refused too often is dropped so a stalled engine frees the host.
	logic [4:0] retry_cnt_q;
	logic [4:0] retry_cnt_d;
	logic retry_d;
	logic abort_d;
	wire blocked = q_push && q_full;

	assign retry_d = blocked && (retry_cnt_q < RETRY_LIMIT);
	assign abort_d = blocked && (retry_cnt_q >= RETRY_LIMIT);
	assign retry_cnt_d = !blocked ? 5'h00 :
		abort_d ? 5'h00 : retry_cnt_q + 5'h01;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			retry_cnt_q <= 5'h00;
			host_retry <= 1'b0;
			host_retry_abort <= 1'b0;
		end else if (clk_en) begin
			retry_cnt_q <= retry_cnt_d;
			host_retry <= retry_d;
			host_retry_abort <= abort_d;
		end
	end

	// Interrupt enable, pending flags and line.
	logic [31:0] ien_q;
	logic [31:0] ien_d;
	logic [1:0] pend_q;
	logic [1:0] pend_d;
	logic irq_n_d;
	wire clr_wr = host_wr && hit_iclr;
	wire [1:0] irq_event = {vline_event, pick_event};
	wire [1:0] irq_clr_bit = {host_wdata[IRQ_VLINE_BIT],
		host_wdata[IRQ_PICK_BIT]};
	wire [1:0] irq_en_bit = {ien_q[IRQ_VLINE_BIT], ien_q[IRQ_PICK_BIT]};

	assign ien_d = (host_wr && hit_ien) ? (host_wdata & IEN_MASK) :
		ien_q;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ien_q <= IEN_RESET;
		end else if (clk_en) begin
			ien_q <= ien_d;
		end
	end

	// Entry 0 is the pick source, entry 1 the vertical line source.
	// A new event in the clearing cycle keeps its flag set.
	for (genvar i = 0; i < 2; i++) begin : g_pend
		assign pend_d[i] = irq_event[i] || (pend_q[i] &&
			!(clr_wr && irq_clr_bit[i]));

		always_ff @(posedge sys_clk or posedge sys_rst) begin
			if (sys_rst) begin
				pend_q[i] <= 1'b0;
			end else if (clk_en) begin
				pend_q[i] <= pend_d[i];
			end
		end
	end

	assign irq_n_d = !((|(pend_q & irq_en_bit)) ||
		(ext_irq && ien_q[IRQ_EXT_BIT]));

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			host_irq_line_n <= 1'b1;
		end else if (clk_en) begin
			host_irq_line_n <= irq_n_d;
		end
	end

	// Read data is captured once at the start of the access and held.
	logic [31:0] rdata_d;

	assign rdata_d = !host_rd_start ? host_rdata :
		hit_status ? status_live :
		hit_ien ? ien_q : 32'h0000_0000;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			host_rdata <= STATUS_RESET;
		end else if (clk_en) begin
			host_rdata <= rdata_d;
		end
	end

	// Pixel datapath.
	logic [31:0] pp_out;
	logic pp_we;
	wire [1:0] depth_field = macc_q[MA_PW_LSB+1:MA_PW_LSB];

	drs_pixel_path u_pixel (
		.fg_colour(foreground_colour_key_q),
		.bg_colour(bg_colour),
		.src_pix(px_src),
		.shade_pix(px_shade),
		.depth(depth_field),
		.block_mode(atype_block),
		.expand(px_expand),
		.expand_bit(px_expand_bit),
		.transc(px_transc),
		.gouraud(px_gouraud),
		.fmt_555(macc_q[MA_D555_BIT]),
		.pix_out(pp_out),
		.pix_we(pp_we)
	);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			px_out <= 32'h0000_0000;
			px_we <= 1'b0;
			px_out_valid <= 1'b0;
		end else if (clk_en) begin
			px_out <= pp_out;
			px_we <= px_valid && pp_we;
			px_out_valid <= px_valid;
		end
	end

	// Configuration outputs.
	wire [3:0] beta_raw = len_q[LEN_BETA_LSB+3:LEN_BETA_LSB];
	wire [4:0] beta_d = !op_hq_hv_load ? vscale_beta :
		(beta_raw == 4'h0) ? BETA_ZERO_VALUE : {1'b0, beta_raw};
	wire tlut_d = macc_q[MA_TLUT_BIT] && (op_host_load || op_blit);
	wire dith_d = !macc_q[MA_NODITH_BIT] &&
		(op_unfmt_load || (op_trap && op_shaded));

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			depth_sel <= DEPTH_8BPP;
			depth_size_32 <= 1'b0;
			mem_reset_cycle <= 1'b0;
			dither_format_select <= 1'b0;
		end else if (clk_en) begin
			depth_sel <= depth_field;
			depth_size_32 <= macc_q[MA_ZW_BIT];
			mem_reset_cycle <= macc_q[MA_MEMRST_BIT];
			dither_format_select <= macc_q[MA_D555_BIT];
		end
	end

	// These follow the operation inputs, so they settle one cycle later.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tlut_target <= 1'b0;
			dither_en <= 1'b0;
			vscale_beta <= BETA_ZERO_VALUE;
		end else if (clk_en) begin
			tlut_target <= tlut_d;
			dither_en <= dith_d;
			vscale_beta <= beta_d;
		end
	end

	// Geometry, colour and queue state as the engine sees them.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			draw_length <= 16'h0000;
			fill_left <= 16'h0000;
			fill_right <= 16'h0000;
			fg_colour <= 32'h0000_0000;
			queue_idle <= 1'b1;
		end else if (clk_en) begin
			draw_length <= len_q[15:0];
			fill_left <= left_q;
			fill_right <= right_q;
			fg_colour <= foreground_colour_key_q;
			queue_idle <= q_empty;
		end
	end
endmodule

// ===== test/drs_host_model.sv
`timescale 1ns/1ps
module drs_host_model
	import drs_pkg::*;
(
	input wire logic sys_clk,
	output logic [13:0] host_addr,
	output logic host_wr,
	output logic [31:0] host_wdata,
	output logic host_rd_start,
	input wire logic [31:0] host_rdata,
	input wire logic host_retry,
	input wire logic host_retry_abort
);
	initial begin
		host_addr = 14'h0000;
		host_wr = 1'b0;
		host_wdata = 32'h0000_0000;
		host_rd_start = 1'b0;
	end
	// The strobe stays up while refused, so the retry count keeps running.
	task automatic wr(input logic [13:0] a, input logic [31:0] d,
		output logic dropped);
		int n;
		@(posedge sys_clk);
		#1;
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			#1;
			if (host_retry !== 1'b1 || host_retry_abort === 1'b1) break;
		end
		if (n == 40) begin
			tb_top.err_total++;
			tb_top.close_out();
		end
		dropped = host_retry_abort;
		host_wr = 1'b0;
		host_addr = ~a;
		host_wdata = ~d;
	endtask
	task automatic rd(input logic [13:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		#1;
		host_addr = a;
		host_rd_start = 1'b1;
		@(posedge sys_clk);
		#1;
		host_rd_start = 1'b0;
		host_addr = ~a;
		d = host_rdata;
	endtask
endmodule

// ===== test/drs_reg_slice_props.sv
`timescale 1ns/1ps
module drs_reg_slice_props
	import drs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic soft_rst,
	input wire logic [13:0] host_addr,
	input wire logic host_wr,
	input wire logic [31:0] host_wdata,
	input wire logic host_rd_start,
	input wire logic [31:0] host_rdata,
	input wire logic host_retry,
	input wire logic eng_ready,
	input wire logic op_trap,
	input wire logic queue_idle,
	input wire logic px_valid,
	input wire logic px_expand,
	input wire logic px_expand_bit,
	input wire logic px_transc,
	input wire logic px_gouraud,
	input wire logic [31:0] px_src,
	input wire logic [31:0] bg_colour,
	input wire logic [31:0] fg_colour,
	input wire logic px_we,
	input wire logic px_out_valid,
	input wire logic [1:0] depth_sel,
	input wire logic depth_size_32,
	input wire logic mem_reset_cycle,
	input wire logic [15:0] draw_length,
	input wire logic [4:0] vscale_beta,
	input wire logic [15:0] fill_left,
	input wire logic [15:0] fill_right
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	wire rd_st = clk_en && host_rd_start && host_addr == OFS_STATUS;
	// A queued write into an idle queue with the engine draining it.
	sequence s_qwr(ofs);
		(clk_en && eng_ready && queue_idle && !soft_rst && host_wr
			&& host_addr == ofs) ##1
		(clk_en && eng_ready && !soft_rst && !host_wr && !op_trap)[*2];
	endsequence
	a_status_zero: assert property (
		rd_st |=> host_rdata[31:10] == 22'h0 && !host_rdata[7])
		else $error("status reserved bits not zero");
	a_flag_pair: assert property (
		rd_st |=> host_rdata[9] == host_rdata[6]
		&& host_rdata[8] == (host_rdata[6:0] == 7'h00))
		else $error("status flags disagree with free count");
	a_rdata_hold: assert property (
		!(clk_en && host_rd_start) |=> $stable(host_rdata))
		else $error("read data moved without a read");
	a_idle_retry: assert property (
		clk_en && host_wr && queue_idle |=> !host_retry)
		else $error("retry with an empty queue");
	a_pair_load: assert property (
		s_qwr(OFS_BND_PAIR) |=>
		{fill_right, fill_left} == $past(host_wdata, 3))
		else $error("boundary pair not split");
	a_cfg_load: assert property (
		s_qwr(OFS_MEM_ACCESS) |=> depth_sel == $past(host_wdata[1:0], 3)
		&& depth_size_32 == $past(host_wdata[3], 3)
		&& mem_reset_cycle == $past(host_wdata[15], 3))
		else $error("config fields wrong");
	a_len_load: assert property (
		s_qwr(OFS_LENGTH) |=> draw_length == $past(host_wdata[15:0], 3))
		else $error("length wrong");
	a_fg_load: assert property (
		s_qwr(OFS_FG_COLOUR) |=> fg_colour == $past(host_wdata, 3))
		else $error("foreground wrong");
	a_beta_range: assert property (
		vscale_beta != 5'h00 && vscale_beta <= 5'h10)
		else $error("scale factor out of range");
	a_expand_we: assert property (
		clk_en && px_valid && px_expand && !px_gouraud |=> px_out_valid
		&& px_we == ($past(px_expand_bit) || !$past(px_transc)))
		else $error("expanded write enable wrong");
	a_key_skip: assert property (
		clk_en && px_valid && !px_expand && !px_gouraud && px_transc
		&& (px_src & bg_colour) == fg_colour ##1 $stable(fg_colour)
		|-> !px_we)
		else $error("keyed pixel written");
endmodule
bind drs_reg_slice drs_reg_slice_props u_props (.*);

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import drs_pkg::*;
	localparam logic [31:0] FG = 32'h9122_3344;
	logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, soft_rst = 1'b0;
	logic [13:0] host_addr;
	logic host_wr, host_rd_start, host_retry, host_retry_abort;
	logic [31:0] host_wdata, host_rdata, px_out, fg_colour, rv;
	logic [31:0] px_src = 32'h0, px_shade = 32'h0, bg_colour = 32'h0000_FFFF;
	logic eng_ready = 1'b1, op_host_load = 1'b0, op_blit = 1'b1;
	logic op_hq_hv_load = 1'b0, op_trap = 1'b0, op_shaded = 1'b0;
	logic op_unfmt_load = 1'b1, atype_block = 1'b0, edge_left_step = 1'b0;
	logic edge_right_step = 1'b0, pick_event = 1'b0, vline_event = 1'b0;
	logic ext_irq = 1'b0, px_valid = 1'b0, px_expand = 1'b0;
	logic px_expand_bit = 1'b0, px_transc = 1'b0, px_gouraud = 1'b0;
	logic [15:0] edge_left_next = 16'h0, edge_right_next = 16'h0;
	logic [15:0] draw_length, fill_left, fill_right;
	logic host_irq_line_n, px_we, px_out_valid, depth_size_32, drop;
	logic mem_reset_cycle, tlut_target, dither_en, dither_format_select;
	logic queue_idle;
	logic [1:0] depth_sel;
	logic [4:0] vscale_beta;
	int err_total = 0, cmp_count = 0;
	always #20 sys_clk = ~sys_clk;
	drs_reg_slice u_dut (.*);
	drs_host_model u_host (.*);
	task automatic close_out;
		if (err_total == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic w(input logic [13:0] a, input logic [31:0] d);
		u_host.wr(a, d, drop);
		for (int k = 0; k < 200 && queue_idle !== 1'b1; k++) tick(1);
		if (queue_idle !== 1'b1) begin
			err_total++;
			close_out();
		end
		tick(4);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(3);
	endtask
	task automatic pxc(input logic [3:0] m, input logic [31:0] s,
		input logic we, input logic [31:0] e, input logic [31:0] k);
		{px_expand, px_expand_bit, px_transc, px_gouraud} = m;
		px_src = s;
		px_valid = 1'b1;
		tick(1);
		px_valid = 1'b0;
		chk("px_vld", 1, 32'(px_out_valid));
		chk("px_we", 32'(we), 32'(px_we));
		chk("px_out", e & k, px_out & k);
	endtask
	initial begin
		tick(12);
		sys_rst = 1'b0;
		chk("beta_rst", 32'h10, 32'(vscale_beta));
		u_host.rd(OFS_STATUS, rv);
		chk("status_rst", 32'h0000_0240, rv);
		u_host.rd(OFS_IEN, rv);
		chk("ien_rst", 32'h0, rv);
		u_host.rd(14'h1000, rv);
		chk("unmapped", 32'h0, rv);
		for (int i = 0; i < 4; i++) begin
			rv = 32'(i) | {i[0], i[1], i[0], 13'h0, i[1], 11'h0, i[0], 3'h0};
			w(OFS_MEM_ACCESS, rv);
			chk("depth", 32'(i), 32'(depth_sel));
			chk("zsize", 32'(i[0]), 32'(depth_size_32));
			chk("memrst", 32'(i[1]), 32'(mem_reset_cycle));
			chk("tlut", 32'(i[0]), 32'(tlut_target));
			chk("dither", 32'(!i[1]), 32'(dither_en));
			chk("fmt555", 32'(i[0]), 32'(dither_format_select));
		end
		op_hq_hv_load = 1'b1;
		w(OFS_LENGTH, 32'h0000_FFFF);
		chk("len", 32'hFFFF, 32'(draw_length));
		chk("beta16", 32'h10, 32'(vscale_beta));
		w(OFS_LENGTH, 32'h1000_0001);
		chk("beta1", 32'h1, 32'(vscale_beta));
		op_hq_hv_load = 1'b0;
		w(OFS_LENGTH, 32'h3000_0002);
		chk("beta_hold", 32'h1, 32'(vscale_beta));
		w(OFS_BND_PAIR, 32'h8000_7FFF);
		chk("pair", 32'h8000_7FFF, {fill_right, fill_left});
		w(OFS_LEFT, 32'hABCD_0011);
		w(OFS_RIGHT, 32'h0000_FFFE);
		edge_left_next = 16'h1234;
		edge_right_next = 16'h5678;
		for (int t = 0; t < 2; t++) begin
			op_trap = t[0];
			edge_left_step = 1'b1;
			edge_right_step = 1'b1;
			tick(1);
			edge_left_step = 1'b0;
			edge_right_step = 1'b0;
			tick(3);
			rv = t ? 32'h5678_1234 : 32'hFFFE_0011;
			chk("scan", rv, {fill_right, fill_left});
		end
		op_trap = 1'b0;
		w(OFS_MEM_ACCESS, 32'h2000_0000);
		op_blit = 1'b0;
		tick(2);
		chk("tlut_none", 0, 32'(tlut_target));
		op_host_load = 1'b1;
		op_unfmt_load = 1'b0;
		tick(2);
		chk("tlut_load", 1, 32'(tlut_target));
		chk("dith_none", 0, 32'(dither_en));
		op_trap = 1'b1;
		op_shaded = 1'b1;
		tick(2);
		chk("dith_trap", 1, 32'(dither_en));
		{op_trap, op_shaded, op_host_load, op_blit} = 4'b0001;
		op_unfmt_load = 1'b1;
		w(OFS_MEM_ACCESS, 32'h0000_0002);
		w(OFS_FG_COLOUR, FG);
		chk("fg", FG, fg_colour);
		pxc(4'b1100, 32'h0, 1, FG, '1);
		pxc(4'b1000, 32'h0, 1, 32'h0000_FFFF, '1);
		pxc(4'b1010, 32'h0, 0, 32'h0, 32'h0);
		bg_colour = 32'hFFFF_FFFF;
		pxc(4'b0010, FG, 0, 32'h0, 32'h0);
		pxc(4'b0010, FG ^ 32'h1, 1, FG ^ 32'h1, '1);
		pxc(4'b0000, FG, 1, FG, '1);
		pxc(4'b0001, 32'h0, 1, FG, 32'hFF00_0000);
		w(OFS_MEM_ACCESS, 32'h0000_0003);
		pxc(4'b1100, 32'h0, 1, FG & 32'h00FF_FFFF, '1);
		atype_block = 1'b1;
		pxc(4'b1100, 32'h0, 1, FG, '1);
		atype_block = 1'b0;
		w(OFS_MEM_ACCESS, 32'h8000_0001);
		pxc(4'b0001, 32'h0, 1, 32'h8000, 32'h8000);
		clk_en = 1'b0;
		u_host.wr(OFS_FG_COLOUR, 32'h0, drop);
		tick(4);
		clk_en = 1'b1;
		tick(4);
		chk("frozen", FG, fg_colour);
		eng_ready = 1'b0;
		for (int i = 0; i < 64; i++) u_host.wr(OFS_FG_COLOUR, 32'(i), drop);
		u_host.rd(OFS_STATUS, rv);
		chk("full", 32'h0000_0100, rv);
		u_host.wr(OFS_FG_COLOUR, 32'hFF, drop);
		chk("abort", 1, 32'(drop));
		eng_ready = 1'b1;
		w(OFS_STATUS, 32'h0);
		chk("order", 32'h3F, fg_colour);
		u_host.rd(OFS_STATUS, rv);
		chk("drained", 32'h0000_0240, rv);
		eng_ready = 1'b0;
		u_host.wr(OFS_FG_COLOUR, 32'h5, drop);
		pulse(soft_rst);
		u_host.rd(OFS_STATUS, rv);
		chk("flush", 32'h0000_0240, rv);
		eng_ready = 1'b1;
		w(OFS_IEN, 32'hFFFF_FFFF);
		u_host.rd(OFS_IEN, rv);
		chk("ien", 32'h64, rv);
		w(OFS_IEN, 32'h20);
		pulse(pick_event);
		chk("irq_mask", 1, 32'(host_irq_line_n));
		w(OFS_IEN, 32'h24);
		chk("irq_pick", 0, 32'(host_irq_line_n));
		w(OFS_ICLR, 32'h4);
		chk("irq_clr2", 1, 32'(host_irq_line_n));
		pulse(vline_event);
		chk("irq_vline", 0, 32'(host_irq_line_n));
		w(OFS_ICLR, 32'h20);
		chk("irq_clr5", 1, 32'(host_irq_line_n));
		ext_irq = 1'b1;
		w(OFS_IEN, 32'h40);
		chk("irq_ext", 0, 32'(host_irq_line_n));
		eng_ready = 1'b0;
		u_host.wr(OFS_FG_COLOUR, 32'h1, drop);
		sys_rst = 1'b1;
		tick(2);
		sys_rst = 1'b0;
		eng_ready = 1'b1;
		chk("irq_hrst", 1, 32'(host_irq_line_n));
		u_host.rd(OFS_STATUS, rv);
		chk("status_hrst", 32'h0000_0240, rv);
		u_host.rd(OFS_IEN, rv);
		chk("ien_hrst", 32'h0, rv);
		close_out();
	end
endmodule
